// *** hw/flash_seq_pkg.sv ***
// constants and types shared by the flash mode sequencer and its fifos.
// assumes one 25 MHz core clock; the read and word program counts below are derived from it.
package flash_seq_pkg;

  // ****************************************************************
  // modes and states
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_READ = 2'h1,
    MODE_PROGRAM = 2'h2,
    MODE_ERASE = 2'h3
  } flash_mode_e;

  typedef enum logic [3:0] {
    ST_INIT = 4'h0,
    ST_STANDBY = 4'h1,
    ST_RD_IDLE = 4'h2,
    ST_RD_BUSY = 4'h3,
    ST_PG_IDLE = 4'h4,
    ST_PG_PRO = 4'h5,
    ST_PG_WORD = 4'h6,
    ST_PG_EPI = 4'h7,
    ST_ER_IDLE = 4'h8
  } seq_state_e;

  // ****************************************************************
  // timing
  // ****************************************************************
  typedef logic [9:0] cnt_t;
  localparam int CLK_PERIOD_PS = 40000;
  localparam int READ_MIN_PS = 46500;
  localparam int READ_MIN_CLKS = 3;
  localparam int READ_CYC_BY_TIME =
    (READ_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_CYC = (READ_CYC_BY_TIME > READ_MIN_CLKS) ?
    READ_CYC_BY_TIME : READ_MIN_CLKS;
  localparam int WORD_PROG_PS = 20700000;
  localparam int WORD_PROG_CYC =
    (WORD_PROG_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PHASE_CYC = 2;
  localparam cnt_t READ_LAST = cnt_t'(READ_CYC - 1);
  localparam cnt_t WORD_LAST = cnt_t'(WORD_PROG_CYC - 1);
  localparam cnt_t PHASE_LAST = cnt_t'(PHASE_CYC - 1);

  // ****************************************************************
  // register selects, mailbox indices, fields
  // ****************************************************************
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_ADDR = 2'h1;
  localparam logic [1:0] SEL_CMD = 2'h2;
  localparam logic [1:0] SEL_STATUS = 2'h3;
  localparam logic [7:0] IDX_DATA_LAST = 8'h03;
  localparam logic [7:0] IDX_ADDR_FIRST = 8'h04;
  localparam logic [7:0] IDX_ADDR_LAST = 8'h07;
  localparam logic [7:0] IDX_CMD = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h0C;
  localparam logic [7:0] IDX_ZERO = 8'h00;
  localparam logic [7:0] IDX_STEP = 8'h01;
  localparam int DATA_COMMIT_BYTE = 3;
  localparam int ADDR_COMMIT_BYTE = 0;
  localparam int ADDR_W = 24;
  localparam int INFO_SEL_BIT = 18;
  localparam logic [31:0] ADDR_INC = 32'h0000_0004;
  localparam int CMD_BURST_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CMD_ERR_BIT = 1;
  localparam int ST_BUSY_ERR_BIT = 2;
  localparam int ST_DATA_FULL_BIT = 3;
  localparam int ST_ADDR_FULL_BIT = 4;
  localparam int ERR_CLR_CMD = 0;
  localparam int ERR_CLR_BUSY = 1;

  // ****************************************************************
  // protection prologue byte loads (arbitrary patterns)
  // ****************************************************************
  localparam logic [1:0] PRO_LAST_STEP = 2'h2;
  localparam logic [ADDR_W-1:0] PRO_ADDR [3] =
    '{24'h000A5A, 24'h0005A5, 24'h000A5A};
  localparam logic [7:0] PRO_DATA [3] = '{8'h3C, 8'hC3, 8'h5A};

endpackage : flash_seq_pkg

// *** hw/flash_word_fifo.sv ***
// two-entry head/tail word fifo with byte writes and auto-increment.
// assumes the owner flushes it and decides when entries are consumed.
`timescale 1ns/1ps
module flash_word_fifo import flash_seq_pkg::*; #(
  parameter int W = 32,
  parameter int COMMIT_BYTE = 0,
  parameter logic [W-1:0] INC = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // tail writes
  input wire logic wr_en,
  input wire logic [W/8-1:0] wr_be,
  input wire logic [W-1:0] wr_data,
  input wire logic ctl_load,
  input wire logic [W-1:0] ctl_data,
  // control
  input wire logic pop,
  input wire logic flush,
  input wire logic auto_inc,
  // state
  output logic [W-1:0] head,
  output logic [W-1:0] tail,
  output logic head_v,
  output logic tail_v,
  output logic full
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic hv;
    logic tv;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (pop) begin
      s_nxt.hv = 1'b0;
    end
    // empty head takes the tail in the same cycle it is freed
    if (!s_nxt.hv && s_r.tv) begin
      s_nxt.head = s_r.tail;
      s_nxt.hv = 1'b1;
      s_nxt.tv = 1'b0;
    end
    if (auto_inc && s_r.hv && !s_r.tv) begin
      s_nxt.tail = s_r.head + INC;
      s_nxt.tv = 1'b1;
    end
    for (int i = 0; i < W / 8; i++) begin
      if (wr_en && wr_be[i]) begin
        s_nxt.tail[i*8 +: 8] = wr_data[i*8 +: 8];
      end
    end
    if (wr_en && wr_be[COMMIT_BYTE]) begin
      s_nxt.tv = 1'b1;
    end
    if (ctl_load) begin
      s_nxt.tail = ctl_data;
      s_nxt.tv = 1'b1;
    end
    if (flush) begin
      s_nxt.hv = 1'b0;
      s_nxt.tv = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign head = s_r.head;
  assign tail = s_r.tail;
  assign head_v = s_r.hv;
  assign tail_v = s_r.tv;
  assign full = s_r.hv && s_r.tv;

endmodule : flash_word_fifo

// *** hw/flash_mode_seq.sv ***
// flash mode sequencer: standby, read, burst read, program, burst program.
// assumes requesters and flash array share core_clk; erase, lock and
// initialization logic sit outside and are not handled here.
`timescale 1ns/1ps

// What this block does
// - standby drops strobes, low power, flushes fifos
// - standby register access completes without error
// - leaving standby, fifos start invalid
// - mode change outside standby forces standby, error
// - command write while busy ignored, error
// - read mode strobes idle when not reading
// - valid address, room: read into data tail
// - address fifo advances after stored read
// - top data byte read advances data fifo
// - data read stalls while lookup pending
// - array read lasts three clocks minimum
// - burst read refills address tail with head+4
// - every word data read advances fifo
// - burst read portal index steps and wraps
// - program head data at head address, advance
// - address bit 18 selects info block
// - prologue before row, epilogue after row
// - busy held through every program sequence
// - word program takes about 20.7 us
// - keep programming; else epilogue, back idle
// - burst program refills address, drops heads
// - burst program portal writes step, commit word
// - mode codes 0..3 standby read program erase
// - address byte 0, data byte 3 commit
module flash_mode_seq import flash_seq_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // word register port (controller and debug)
  input wire logic ec_req,
  input wire logic ec_we,
  input wire logic [1:0] ec_sel,
  input wire logic [3:0] ec_be,
  input wire logic [31:0] ec_wdata,
  output logic [31:0] ec_rdata,
  output logic ec_stall,
  // host byte mailbox
  input wire logic mbx_index_wr,
  input wire logic [7:0] mbx_index_wdata,
  input wire logic mbx_data_wr,
  input wire logic mbx_data_rd,
  input wire logic [7:0] mbx_wdata,
  output logic [7:0] mbx_rdata,
  output logic [7:0] mailbox_index_portal,
  // status and error clear
  input wire logic [1:0] err_clr,
  output logic [1:0] flash_mode,
  output logic burst_en,
  output logic busy,
  output logic cmd_err,
  output logic busy_err,
  output logic data_full,
  output logic addr_full,
  // flash array
  output logic [ADDR_W-1:0] fl_addr,
  output logic [31:0] fl_wdata,
  input wire logic [31:0] fl_rdata,
  output logic fl_read_en,
  output logic fl_load_en,
  output logic fl_prog_en,
  output logic fl_prog_start,
  output logic fl_info_sel,
  output logic fl_low_power
);

  typedef struct packed {
    seq_state_e st;
    flash_mode_e mode;
    logic burst;
    cnt_t cnt;
    logic [1:0] step;
    logic cmd_err;
    logic busy_err;
    logic [7:0] index;
    logic [31:0] ec_rdata;
    logic [7:0] mbx_rdata;
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  logic [31:0] d_head, d_tail, a_head, a_tail;
  logic d_hv, d_tv, d_full, a_hv, a_tv, a_full;
  logic ec_rd_data, ec_take, cmd_wr, in_standby, read_done, word_done;
  logic mbx_is_data, mbx_is_addr, burst_rd, burst_pg, auto_inc, lookup_due;
  logic d_wr_en, a_wr_en, d_pop, a_pop;
  logic [3:0] d_be, a_be, mbx_be;
  logic [31:0] d_wdata, a_wdata, status_w;
  logic [7:0] cmd_byte;
  flash_mode_e cmd_mode;

  // ****************************************************************
  // request decode
  // ****************************************************************
  // busy spans every sequence
  assign busy = (s_r.st == ST_RD_BUSY) || (s_r.st == ST_PG_PRO) ||
    (s_r.st == ST_PG_WORD) || (s_r.st == ST_PG_EPI);
  assign in_standby = (s_r.st == ST_STANDBY) || (s_r.st == ST_INIT);
  assign ec_rd_data = ec_req && !ec_we && (ec_sel == SEL_DATA);
  // stall until the word reaches the head
  assign lookup_due = (s_r.st == ST_RD_BUSY) || d_tv ||
    ((s_r.st == ST_RD_IDLE) && (a_hv || a_tv));
  assign ec_stall = ec_rd_data && !d_hv && lookup_due;
  assign ec_take = ec_req && !ec_stall;
  assign mbx_is_data = s_r.index <= IDX_DATA_LAST;
  assign mbx_is_addr = (s_r.index >= IDX_ADDR_FIRST) &&
    (s_r.index <= IDX_ADDR_LAST);
  assign mbx_be = 4'h1 << s_r.index[1:0];
  assign burst_rd = s_r.burst && (s_r.mode == MODE_READ);
  assign burst_pg = s_r.burst && (s_r.mode == MODE_PROGRAM);
  assign cmd_wr = (ec_take && ec_we && (ec_sel == SEL_CMD) && ec_be[0]) ||
    (mbx_data_wr && (s_r.index == IDX_CMD));
  assign cmd_byte = (ec_take && ec_we) ? ec_wdata[7:0] : mbx_wdata;
  assign cmd_mode = flash_mode_e'(cmd_byte[1:0]);
  assign read_done = (s_r.st == ST_RD_BUSY) && (s_r.cnt == '0);
  assign word_done = (s_r.st == ST_PG_WORD) && (s_r.cnt == '0);

  // ****************************************************************
  // fifo control
  // ****************************************************************
  assign d_wr_en = (ec_take && ec_we && (ec_sel == SEL_DATA)) ||
    (mbx_data_wr && mbx_is_data);
  assign d_be = (ec_take && ec_we) ? ec_be : mbx_be;
  assign d_wdata = (ec_take && ec_we) ? ec_wdata : {4{mbx_wdata}};
  assign a_wr_en = (ec_take && ec_we && (ec_sel == SEL_ADDR)) ||
    (mbx_data_wr && mbx_is_addr);
  assign a_be = (ec_take && ec_we) ? ec_be : mbx_be;
  assign a_wdata = d_wdata;
  // reads and finished word programs that consume the head word
  assign d_pop = (ec_take && ec_rd_data) ||
    (mbx_data_rd && (s_r.index == IDX_DATA_LAST)) ||
    word_done;
  assign a_pop = read_done || word_done;
  assign auto_inc = burst_rd || burst_pg;

  // address commits on byte 0, data on byte 3
  flash_word_fifo #(
    .W(32),
    .COMMIT_BYTE(DATA_COMMIT_BYTE),
    .INC('0)
  ) u_data_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(d_wr_en),
    .wr_be(d_be),
    .wr_data(d_wdata),
    .ctl_load(read_done),
    .ctl_data(fl_rdata),
    .pop(d_pop),
    .flush(in_standby),
    .auto_inc(1'b0),
    .head(d_head),
    .tail(d_tail),
    .head_v(d_hv),
    .tail_v(d_tv),
    .full(d_full)
  );

  flash_word_fifo #(
    .W(32),
    .COMMIT_BYTE(ADDR_COMMIT_BYTE),
    .INC(ADDR_INC)
  ) u_addr_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(a_wr_en),
    .wr_be(a_be),
    .wr_data(a_wdata),
    .ctl_load(1'b0),
    .ctl_data('0),
    .pop(a_pop),
    .flush(in_standby),
    .auto_inc(auto_inc),
    .head(a_head),
    .tail(a_tail),
    .head_v(a_hv),
    .tail_v(a_tv),
    .full(a_full)
  );

  always_comb begin
    status_w = '0;
    status_w[ST_BUSY_BIT] = busy;
    status_w[ST_CMD_ERR_BIT] = s_r.cmd_err;
    status_w[ST_BUSY_ERR_BIT] = s_r.busy_err;
    status_w[ST_DATA_FULL_BIT] = d_full;
    status_w[ST_ADDR_FULL_BIT] = a_full;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    logic [31:0] sh;
    sh = '0;
    s_nxt = s_r;
    // clears first so a same-cycle set wins
    if (err_clr[ERR_CLR_CMD]) s_nxt.cmd_err = 1'b0;
    if (err_clr[ERR_CLR_BUSY]) s_nxt.busy_err = 1'b0;
    if (s_r.cnt != '0) s_nxt.cnt = s_r.cnt - cnt_t'(1);
    case (s_r.st)
      // one pass through init, then standby
      ST_INIT: s_nxt.st = ST_STANDBY;
      ST_STANDBY, ST_ER_IDLE, ST_PG_IDLE, ST_RD_IDLE: begin
        if ((s_r.st == ST_RD_IDLE) && a_hv && !d_full) begin
          s_nxt.st = ST_RD_BUSY;
          s_nxt.cnt = READ_LAST;
        end
        if ((s_r.st == ST_PG_IDLE) && a_hv && d_hv) begin
          s_nxt.st = ST_PG_PRO;
          s_nxt.step = '0;
          s_nxt.cnt = PHASE_LAST;
        end
      end
      ST_RD_BUSY: if (read_done) s_nxt.st = ST_RD_IDLE;
      ST_PG_PRO: begin
        if (s_r.cnt == '0) begin
          s_nxt.cnt = PHASE_LAST;
          s_nxt.step = s_r.step + 2'h1;
          if (s_r.step == PRO_LAST_STEP) begin
            s_nxt.st = ST_PG_WORD;
            s_nxt.cnt = WORD_LAST;
          end
        end
      end
      ST_PG_WORD: begin
        if (word_done) begin
          // continue while next words are ready
          if (a_tv && d_tv) begin
            s_nxt.cnt = WORD_LAST;
          end else begin
            s_nxt.st = ST_PG_EPI;
            s_nxt.cnt = PHASE_LAST;
          end
        end
      end
      ST_PG_EPI: if (s_r.cnt == '0) s_nxt.st = ST_PG_IDLE;
      default: s_nxt.st = ST_STANDBY;
    endcase
    if (cmd_wr) begin
      if (busy) begin
        s_nxt.busy_err = 1'b1;
      end else if ((s_r.mode != MODE_STANDBY) &&
                   (cmd_mode != MODE_STANDBY)) begin
        s_nxt.mode = MODE_STANDBY;
        s_nxt.st = ST_STANDBY;
        s_nxt.cmd_err = 1'b1;
      end else begin
        s_nxt.mode = cmd_mode;
        s_nxt.burst = cmd_byte[CMD_BURST_BIT];
        case (cmd_mode)
          MODE_READ: s_nxt.st = ST_RD_IDLE;
          MODE_PROGRAM: s_nxt.st = ST_PG_IDLE;
          MODE_ERASE: s_nxt.st = ST_ER_IDLE;
          default: s_nxt.st = ST_STANDBY;
        endcase
      end
    end
    // portal index steps on burst data access
    if (mbx_index_wr) begin
      s_nxt.index = mbx_index_wdata;
    end else if (mbx_is_data && ((burst_rd && mbx_data_rd) ||
                                 (burst_pg && mbx_data_wr))) begin
      s_nxt.index = (s_r.index == IDX_DATA_LAST) ? IDX_ZERO :
        s_r.index + IDX_STEP;
    end
    if (ec_take && !ec_we) begin
      case (ec_sel)
        SEL_DATA: s_nxt.ec_rdata = d_head;
        SEL_ADDR: s_nxt.ec_rdata = a_head;
        SEL_CMD: s_nxt.ec_rdata = {29'h0, s_r.burst, s_r.mode};
        default: s_nxt.ec_rdata = status_w;
      endcase
    end
    if (mbx_data_rd) begin
      if (mbx_is_data) sh = d_head >> {s_r.index[1:0], 3'h0};
      else if (mbx_is_addr) sh = a_head >> {s_r.index[1:0], 3'h0};
      else if (s_r.index == IDX_CMD) sh = {29'h0, s_r.burst, s_r.mode};
      else if (s_r.index == IDX_STATUS) sh = status_w;
      s_nxt.mbx_rdata = sh[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign ec_rdata = s_r.ec_rdata;
  assign mbx_rdata = s_r.mbx_rdata;
  assign mailbox_index_portal = s_r.index;
  assign flash_mode = s_r.mode;
  assign burst_en = s_r.burst;
  assign cmd_err = s_r.cmd_err;
  assign busy_err = s_r.busy_err;
  assign data_full = d_full;
  assign addr_full = a_full;
  assign fl_read_en = s_r.st == ST_RD_BUSY;
  assign fl_load_en = s_r.st == ST_PG_PRO;
  assign fl_prog_en = s_r.st == ST_PG_WORD;
  assign fl_prog_start = s_r.st == ST_PG_EPI;
  // low power whenever nothing is strobed
  assign fl_low_power = !busy;
  assign fl_addr = fl_load_en ? PRO_ADDR[s_r.step] : a_head[ADDR_W-1:0];
  assign fl_wdata = fl_load_en ? {24'h0, PRO_DATA[s_r.step]} : d_head;
  assign fl_info_sel = fl_prog_en && a_head[INFO_SEL_BIT];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  sequence seq_read_pulse;
    fl_read_en [*3] ##1 !fl_read_en;
  endsequence

  a_standby_quiet: assert property (
    (s_r.st == ST_STANDBY) |-> fl_low_power && !fl_read_en && !fl_prog_en)
    else $error("strobe active in standby");
  a_standby_flush: assert property (
    (s_r.st == ST_STANDBY) && $past(s_r.st == ST_STANDBY) |->
      !a_hv && !a_tv && !d_hv && !d_tv)
    else $error("fifo valid in standby");
  a_mode_hop: assert property (
    cmd_wr && !busy && (s_r.mode != MODE_STANDBY) &&
    (cmd_mode != MODE_STANDBY) |=> (s_r.mode == MODE_STANDBY) && cmd_err)
    else $error("illegal mode change not refused");
  a_busy_write: assert property (
    cmd_wr && busy |=> busy_err && $stable(s_r.mode))
    else $error("command taken while busy");
  a_read_len: assert property (
    $rose(fl_read_en) |-> seq_read_pulse)
    else $error("array read length wrong");
  a_read_store: assert property (
    read_done |=> d_tv || d_hv)
    else $error("read result not stored");
  a_read_stall: assert property (
    ec_rd_data && !d_hv && (s_r.st == ST_RD_BUSY) |->
      ec_stall ##1 (ec_stall || d_hv || !ec_rd_data))
    else $error("read not stalled during lookup");
  a_burst_inc: assert property (
    burst_rd && (s_r.st == ST_RD_IDLE) && a_hv && !a_tv && !cmd_wr &&
    !a_wr_en |=> a_tv && (a_tail == $past(a_head) + ADDR_INC))
    else $error("burst address not advanced");
  a_index_wrap: assert property (
    burst_rd && mbx_data_rd && !mbx_index_wr &&
    (s_r.index == IDX_DATA_LAST) |=> s_r.index == IDX_ZERO)
    else $error("portal index did not wrap");
  a_prog_busy: assert property (
    fl_load_en || fl_prog_en || fl_prog_start |-> busy)
    else $error("busy low in program sequence");
  a_info_sel: assert property (
    fl_prog_en |-> fl_info_sel == a_head[INFO_SEL_BIT])
    else $error("info select wrong");

endmodule : flash_mode_seq

// *** sim/flash_array_model.sv ***
// behavioural flash array: answers reads, tallies strobes, keeps last word.
// assumes level strobes from the sequencer on core_clk.
`timescale 1ns/1ps
module flash_array_model import flash_seq_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // strobes
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [31:0] fl_wdata,
  input wire logic fl_read_en,
  input wire logic fl_load_en,
  input wire logic fl_prog_en,
  input wire logic fl_prog_start,
  input wire logic fl_info_sel,
  input wire logic fl_low_power,
  input wire logic busy,
  // array data
  output logic [31:0] fl_rdata,
  // tallies
  output int n_rd,
  output int n_load,
  output int n_prog,
  output int n_epi,
  output int n_bad,
  output logic [ADDR_W-1:0] pg_addr,
  output logic [31:0] pg_data,
  output logic pg_info
);
  logic [31:0] held;
  logic pgm;
  // ****************************************************************
  // read data
  // ****************************************************************
  // off-strobe the bus shows the inverse of the last word, not a stale copy
  assign fl_rdata = fl_read_en ? {8'h5A, fl_addr} : ~held;
  assign pgm = fl_load_en | fl_prog_en | fl_prog_start;
  always @(posedge core_clk) begin
    if (rst) begin
      held <= 32'h0;
      {n_rd, n_load, n_prog, n_epi, n_bad} <= '0;
    end else begin
      if (fl_read_en) begin
        held <= {8'h5A, fl_addr};
        n_rd <= n_rd + 1;
      end
      n_load <= n_load + int'(fl_load_en);
      n_epi <= n_epi + int'(fl_prog_start);
      if (fl_prog_en) begin
        n_prog <= n_prog + 1;
        pg_addr <= fl_addr;
        pg_data <= fl_wdata;
        pg_info <= fl_info_sel;
      end
      // low power exactly when idle, busy in program
      if ((fl_low_power !== !(pgm | fl_read_en)) || (pgm && busy !== 1'b1))
        n_bad <= n_bad + 1;
    end
  end
endmodule : flash_array_model

// *** sim/tb_flash_mode_seq.sv ***
// bench for the flash mode sequencer: word port and mailbox tasks.
// assumes the behavioural array model answers the array strobes.
`timescale 1ns/1ps
module tb_flash_mode_seq import flash_seq_pkg::*; ;
  logic core_clk, rst, clk_en, ec_req, ec_we, ec_stall, busy, burst_en;
  logic [1:0] ec_sel, err_clr, flash_mode;
  logic [3:0] ec_be;
  logic [31:0] ec_wdata, ec_rdata, fl_wdata, fl_rdata, r, pg_data;
  logic mbx_index_wr, mbx_data_wr, mbx_data_rd, cmd_err, busy_err;
  logic [7:0] mbx_index_wdata, mbx_wdata, mbx_rdata, mailbox_index_portal;
  logic data_full, addr_full, fl_read_en, fl_load_en, fl_prog_en;
  logic fl_prog_start, fl_info_sel, fl_low_power, pg_info;
  logic [ADDR_W-1:0] fl_addr, pg_addr;
  int n_rd, n_load, n_prog, n_epi, n_bad, fails, total_checks, cycles;

  flash_mode_seq u_flash_mode_seq (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .ec_req(ec_req),
    .ec_we(ec_we), .ec_sel(ec_sel), .ec_be(ec_be), .ec_wdata(ec_wdata),
    .ec_rdata(ec_rdata), .ec_stall(ec_stall), .mbx_index_wr(mbx_index_wr),
    .mbx_index_wdata(mbx_index_wdata), .mbx_data_wr(mbx_data_wr),
    .mbx_data_rd(mbx_data_rd), .mbx_wdata(mbx_wdata),
    .mbx_rdata(mbx_rdata), .mailbox_index_portal(mailbox_index_portal),
    .err_clr(err_clr), .flash_mode(flash_mode), .burst_en(burst_en),
    .busy(busy), .cmd_err(cmd_err), .busy_err(busy_err),
    .data_full(data_full), .addr_full(addr_full), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .fl_read_en(fl_read_en),
    .fl_load_en(fl_load_en), .fl_prog_en(fl_prog_en),
    .fl_prog_start(fl_prog_start), .fl_info_sel(fl_info_sel),
    .fl_low_power(fl_low_power));

  flash_array_model u_flash_array_model (
    .core_clk(core_clk), .rst(rst), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_read_en(fl_read_en), .fl_load_en(fl_load_en),
    .fl_prog_en(fl_prog_en), .fl_prog_start(fl_prog_start),
    .fl_info_sel(fl_info_sel), .fl_low_power(fl_low_power), .busy(busy),
    .fl_rdata(fl_rdata), .n_rd(n_rd), .n_load(n_load), .n_prog(n_prog),
    .n_epi(n_epi), .n_bad(n_bad), .pg_addr(pg_addr), .pg_data(pg_data),
    .pg_info(pg_info));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // request held until an edge sees no stall; one idle edge follows
  task automatic ec(input logic we, input logic [1:0] sel,
    input logic [31:0] wd);
    logic s;
    ec_req = 1'b1;
    ec_we = we;
    ec_sel = sel;
    ec_wdata = wd;
    do begin
      @(negedge core_clk);
      s = ec_stall;
      cyc(1);
    end while (s);
    ec_req = 1'b0;
    r = ec_rdata;
    cyc(1);
  endtask : ec

  task automatic st(input logic [4:0] exp);
    ec(1'b0, SEL_STATUS, 32'h0);
    chk(32'(r[4:0]), 32'(exp));
  endtask : st

  // kind 0 index write, 1 data write, 2 data read
  task automatic mb(input logic [1:0] k, input logic [7:0] d);
    mbx_index_wr = (k == 2'h0);
    mbx_data_wr = (k == 2'h1);
    mbx_data_rd = (k == 2'h2);
    mbx_index_wdata = d;
    mbx_wdata = d;
    cyc(1);
    {mbx_index_wr, mbx_data_wr, mbx_data_rd} = 3'h0;
    cyc(1);
  endtask : mb

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ceiling well above three word programs plus the reads
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    {fails, total_checks, cycles} = '0;
    {rst, clk_en, ec_be} = 6'h3F;
    {ec_req, ec_we, ec_sel, ec_wdata, err_clr} = '0;
    {mbx_index_wr, mbx_data_wr, mbx_data_rd} = 3'h0;
    {mbx_index_wdata, mbx_wdata} = 16'h0;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk(32'(flash_mode), 32'h0);
    st(5'h00);
    ec(1'b1, SEL_ADDR, 32'h0000_1000);
    st(5'h00);
    ec(1'b1, SEL_CMD, 32'h0000_0001);
    chk(32'(flash_mode), 32'h1);
    cyc(4);
    chk(32'(n_rd), 32'h0);
    ec(1'b1, SEL_ADDR, 32'h0000_0123);
    ec(1'b0, SEL_DATA, 32'h0);
    chk(r, 32'h5A00_0123);
    chk(32'(n_rd), 32'(READ_CYC));
    st(5'h00);
    ec(1'b1, SEL_CMD, 32'h0000_0002);
    chk(32'(flash_mode), 32'h0);
    st(5'h02);
    err_clr = 2'h1;
    cyc(1);
    err_clr = 2'h0;
    st(5'h00);
    // burst read through the word port, then the mailbox
    ec(1'b1, SEL_CMD, 32'h0000_0005);
    chk(32'(burst_en), 32'h1);
    ec(1'b1, SEL_ADDR, 32'h0000_0200);
    for (int i = 0; i < 3; i++) begin
      ec(1'b0, SEL_DATA, 32'h0);
      chk(r, 32'h5A00_0200 + 32'(4 * i));
    end
    cyc(12);
    st(5'h18);
    mb(2'h0, 8'h00);
    for (int i = 0; i < 5; i++) begin
      mb(2'h2, 8'h00);
      chk(32'(mbx_rdata),
        32'(8'(64'h5A00_0210_5A00_020C >> (8 * i))));
      chk(32'(mailbox_index_portal), 32'((i + 1) % 4));
    end
    cyc(10);
    // single word program into the info block
    ec(1'b1, SEL_CMD, 32'h0000_0000);
    ec(1'b1, SEL_CMD, 32'h0000_0002);
    ec(1'b1, SEL_ADDR, 32'h0004_0010);
    ec(1'b1, SEL_DATA, 32'hCAFE_0001);
    cyc(3);
    ec(1'b1, SEL_CMD, 32'h0000_0000);
    chk(32'(flash_mode), 32'h2);
    st(5'h05);
    while (busy) cyc(1);
    chk(32'(n_load), 32'(3 * PHASE_CYC));
    chk(32'(n_epi), 32'(PHASE_CYC));
    chk(32'(n_prog), 32'(WORD_PROG_CYC));
    chk(32'(pg_addr), 32'h0004_0010);
    chk(pg_data, 32'hCAFE_0001);
    chk(32'(pg_info), 32'h1);
    st(5'h04);
    err_clr = 2'h2;
    cyc(1);
    err_clr = 2'h0;
    // burst program of two words through the mailbox, one row
    ec(1'b1, SEL_CMD, 32'h0000_0000);
    ec(1'b1, SEL_CMD, 32'h0000_0006);
    ec(1'b1, SEL_ADDR, 32'h0000_0100);
    mb(2'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      mb(2'h1, 8'(8'h11 * (i + 1)));
      chk(32'(mailbox_index_portal), 32'((i + 1) % 4));
    end
    while (busy) cyc(1);
    chk(32'(n_epi), 32'(2 * PHASE_CYC));
    chk(32'(n_load), 32'(6 * PHASE_CYC));
    chk(32'(n_prog), 32'(3 * WORD_PROG_CYC));
    chk(32'(pg_addr), 32'h0000_0104);
    chk(pg_data, 32'h8877_6655);
    chk(32'(pg_info), 32'h0);
    chk(32'(n_bad), 32'h0);
    complete_run();
  end
endmodule : tb_flash_mode_seq
